//--- rtl/spc_pkg.sv
// Shared constants, carrier types and enumerations of the solar pump controller
package spc_pkg;

    // Clock rate and time bases
    localparam int  CLK_HZ       = 40_000_000;
    localparam int  SAMPLE_MS    = 100;
    localparam int  BLINK_MS     = 250;
    localparam int  SAMPLE_CYC   = (SAMPLE_MS * (CLK_HZ / 1000));
    localparam int  BLINK_CYC    = (BLINK_MS * (CLK_HZ / 1000));

    // Temperatures are whole degrees Celsius, two's complement
    localparam int  TEMP_W       = 9;
    typedef logic signed [TEMP_W-1:0] spc_temp_t;

    localparam spc_temp_t OVER_ON_C  = 9'sh082;   // 130 C
    localparam spc_temp_t OVER_OFF_C = 9'sh06E;   // 110 C
    localparam logic [6:0] HYST_K    = 7'h03;     // 3 K
    localparam logic [6:0] DIFF_MIN  = 7'h02;     // 2 K
    localparam logic [6:0] DIFF_MAX  = 7'h0C;     // 12 K
    localparam logic [6:0] MAX_MIN   = 7'h28;     // 40 C
    localparam logic [6:0] MAX_MAX   = 7'h64;     // 100 C

    // Lamp bar thresholds, lowest lamp first
    localparam spc_temp_t LAMP_T0    = 9'sh000;
    localparam spc_temp_t LAMP_T1    = 9'sh019;
    localparam spc_temp_t LAMP_T2    = 9'sh032;
    localparam spc_temp_t LAMP_T3    = 9'sh04B;

    // Selector bits: bit 1 picks solar, bit 0 picks silicon sensors
    localparam int  SEL_SOLAR    = 1;
    localparam int  SEL_SILICON  = 0;

    // Mode switch codes
    typedef enum logic [1:0] {
        SPC_MODE_OFF  = 2'h0,
        SPC_MODE_AUTO = 2'h1,
        SPC_MODE_ON   = 2'h2
    } spc_mode_t;

    // Collector over-temperature lock
    typedef enum logic [0:0] {
        SPC_OT_RUN   = 1'h0,
        SPC_OT_BLOCK = 1'h1
    } spc_ot_t;

    // One measured sensor as delivered by the front end
    typedef struct packed {
        logic      open;
        logic      shorted;
        spc_temp_t temp;
    } spc_sensor_t;

    // Master to slave link word
    typedef struct packed {
        logic      coll_fault;
        logic      master_pump;
        logic      shared_pump_cmd;
        spc_temp_t coll_temp;
    } spc_down_t;

    // Slave to master link word
    typedef struct packed {
        logic tank_ok;
        logic valve_request;
    } spc_up_t;

endpackage

//--- rtl/spc_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module spc_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;

    // First stage feeds only the second one
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

//--- rtl/spc_controller.sv
// Differential temperature pump controller with master and slave link
// How it works
// - Selector picks solar or feed program with platinum or silicon sensors
// - Mode switch forces pump off, runs automatic, or forces pump on
// - Forced on ignores temperature limits and sensor faults
// - Solar: run while collector above tank plus diff and tank below max
// - Solar: collector above 130 C blocks pump until below 110 C
// - During that block the two top collector lamps flash while the collector sensor has not failed
// - Feed: run while boiler above threshold and above tank plus diff
// - Master sends collector temperature; slave uses it with its own tank
// - Two-pump: slave pump only while master pump off and own start holds
// - Slave with open collector input uses two-pump mode
// - Pump-valve: master start lost, master runs pump, slave opens valve
// - Slave with shorted collector input uses pump-valve mode
// - Shorted sensor blinks lowest lamp, open sensor blinks top lamp; slave collector display blinks top lamp for either
// - Failed slave tank sensor puts master in stand-alone control
// - Failed master collector sensor switches pump and valve outputs of both units off in automatic mode
// - Diff setting 2 to 12 K with 3 K switching hysteresis
`timescale 1ns/10ps
module spc_controller #(
    parameter int SAMPLE_CYC = spc_pkg::SAMPLE_CYC,
    parameter int BLINK_CYC  = spc_pkg::BLINK_CYC
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire logic [1:0]          program_sel,
    input  wire logic [1:0]          mode_sel,
    input  wire logic                slave_role,
    input  wire logic [3:0]          diff_setting,
    input  wire logic [6:0]          max_setting,
    input  wire spc_pkg::spc_sensor_t collector_sensor,
    input  wire spc_pkg::spc_sensor_t tank_sensor,
    input  wire spc_pkg::spc_down_t  link_down_in,
    input  wire spc_pkg::spc_up_t    link_up_in,
    output spc_pkg::spc_down_t       link_down_out,
    output spc_pkg::spc_up_t         link_up_out,
    output logic                     sensor_silicon,
    output logic                     pump_out,
    output logic                     valve_out,
    output logic [3:0]               coll_lamp,
    output logic [3:0]               tank_lamp
);
    localparam int PIN_W = 2 + 2 + 1 + 4 + 7 + 2 * $bits(spc_pkg::spc_sensor_t)
                         + $bits(spc_pkg::spc_down_t) + $bits(spc_pkg::spc_up_t);

    logic [1:0]           s_prog;
    logic [1:0]           s_mode_raw;
    logic                 s_slave;
    logic [3:0]           s_diff;
    logic [6:0]           s_max;
    spc_pkg::spc_sensor_t s_coll;
    spc_pkg::spc_sensor_t s_tank;
    spc_pkg::spc_down_t   s_down;
    spc_pkg::spc_up_t     s_up;

    // Every pin level crosses two flip-flops before use
    spc_sync #(.W(PIN_W)) u_sync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .din     ({program_sel, mode_sel, slave_role, diff_setting, max_setting,
                   collector_sensor, tank_sensor, link_down_in, link_up_in}),
        .dout    ({s_prog, s_mode_raw, s_slave, s_diff, s_max, s_coll, s_tank, s_down, s_up})
    );

    // Clamp a value into a documented range
    function automatic logic [6:0] clamp7(input logic [6:0] v, input logic [6:0] lo, input logic [6:0] hi);
        clamp7 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Bar display of a temperature, lowest lamp first
    function automatic logic [3:0] lamp_bar(input spc_pkg::spc_temp_t t);
        lamp_bar = {t > spc_pkg::LAMP_T3, t > spc_pkg::LAMP_T2, t > spc_pkg::LAMP_T1, t > spc_pkg::LAMP_T0};
    endfunction

    // Fault blink: short lights lowest lamp, open lights top lamp
    function automatic logic [3:0] lamp_show(input spc_pkg::spc_sensor_t s, input logic blink);
        if (s.shorted)
            lamp_show = {3'h0, blink};
        else if (s.open)
            lamp_show = {blink, 3'h0};
        else
            lamp_show = lamp_bar(s.temp);
    endfunction

    // Sample and blink timers
    logic [31:0] smp_cnt, next_smp_cnt;
    logic [31:0] blk_cnt, next_blk_cnt;
    logic        blink, next_blink;
    logic        tick;

    assign tick = (smp_cnt == 32'(SAMPLE_CYC - 1));

    always_comb begin
        next_smp_cnt = tick ? 32'h0 : smp_cnt + 32'h1;
        next_blk_cnt = (blk_cnt == 32'(BLINK_CYC - 1)) ? 32'h0 : blk_cnt + 32'h1;
        next_blink   = (blk_cnt == 32'(BLINK_CYC - 1)) ? !blink : blink;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            smp_cnt <= 32'h0;
            blk_cnt <= 32'h0;
            blink   <= 1'b0;
        end else begin
            smp_cnt <= next_smp_cnt;
            blk_cnt <= next_blk_cnt;
            blink   <= next_blink;
        end
    end

    // Decoded configuration
    spc_pkg::spc_mode_t mode;
    logic               solar;
    logic               two_pump;
    logic               pump_valve;
    logic [6:0]         diff_eff;
    logic [6:0]         max_eff;

    // Code 3 on the mode switch is treated as off, the safe side
    assign mode       = (s_mode_raw == 2'h3) ? spc_pkg::SPC_MODE_OFF : spc_pkg::spc_mode_t'(s_mode_raw);
    assign solar      = s_prog[spc_pkg::SEL_SOLAR];
    assign two_pump   = s_slave && s_coll.open;
    assign pump_valve = s_slave && s_coll.shorted && !s_coll.open;
    assign diff_eff   = clamp7({3'h0, s_diff}, spc_pkg::DIFF_MIN, spc_pkg::DIFF_MAX);
    assign max_eff    = clamp7(s_max, spc_pkg::MAX_MIN, spc_pkg::MAX_MAX);

    // Collector value: own sensor on the master, link value on the slave
    spc_pkg::spc_temp_t coll_t;
    logic               coll_fail;
    logic               tank_fail;
    assign coll_t    = s_slave ? s_down.coll_temp : s_coll.temp;
    assign coll_fail = s_slave ? s_down.coll_fault : (s_coll.open || s_coll.shorted);
    assign tank_fail = s_tank.open || s_tank.shorted;

    // Comparison levels, widened so sums never wrap
    logic signed [10:0] c11, t11, on_lvl, off_lvl, max11, max_lo;
    assign c11     = 11'(coll_t);
    assign t11     = 11'(s_tank.temp);
    assign on_lvl  = t11 + $signed({4'h0, diff_eff});
    assign off_lvl = on_lvl - $signed({4'h0, spc_pkg::HYST_K});
    assign max11   = $signed({4'h0, max_eff});
    assign max_lo  = max11 - $signed({4'h0, spc_pkg::HYST_K});

    // Hysteretic comparators and over-temperature lock, updated per sample
    logic            diff_on, next_diff_on;
    logic            thr_ok, next_thr_ok;
    spc_pkg::spc_ot_t ot_state, next_ot_state;

    always_comb begin
        next_diff_on  = diff_on;
        next_thr_ok   = thr_ok;
        next_ot_state = ot_state;
        if (tick) begin
            next_diff_on = diff_on ? (c11 > off_lvl) : (c11 > on_lvl);
            if (solar)
                next_thr_ok = thr_ok ? (t11 < max11) : (t11 < max_lo);
            else
                next_thr_ok = thr_ok ? (c11 > max_lo) : (c11 > max11);
            unique case (ot_state)
                spc_pkg::SPC_OT_RUN:   if (coll_t > spc_pkg::OVER_ON_C) next_ot_state = spc_pkg::SPC_OT_BLOCK;
                spc_pkg::SPC_OT_BLOCK: if (coll_t < spc_pkg::OVER_OFF_C) next_ot_state = spc_pkg::SPC_OT_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            diff_on  <= 1'b0;
            thr_ok   <= 1'b0;
            ot_state <= spc_pkg::SPC_OT_RUN;
        end else begin
            diff_on  <= next_diff_on;
            thr_ok   <= next_thr_ok;
            ot_state <= next_ot_state;
        end
    end

    // Own start condition; the lock only applies to the solar collector
    logic own_start;
    assign own_start = diff_on && thr_ok && !coll_fail && !tank_fail
                    && !(solar && ot_state == spc_pkg::SPC_OT_BLOCK);

    // Registered outputs and link words
    logic               next_pump, next_valve;
    spc_pkg::spc_down_t next_down;
    spc_pkg::spc_up_t   next_up;
    logic               auto_pump, auto_valve, slave_ok, shared_cmd;

    always_comb begin
        slave_ok   = s_up.tank_ok;
        shared_cmd = !s_slave && !own_start && slave_ok && s_up.valve_request && !coll_fail;
        if (s_slave) begin
            auto_pump  = two_pump && own_start && !s_down.master_pump;
            auto_valve = pump_valve && s_down.shared_pump_cmd && !coll_fail;
        end else begin
            auto_pump  = (own_start || shared_cmd) && !coll_fail;
            auto_valve = 1'b0;
        end
        next_pump  = pump_out;
        next_valve = valve_out;
        next_down  = link_down_out;
        next_up    = link_up_out;
        if (tick) begin
            unique case (mode)
                spc_pkg::SPC_MODE_OFF:  next_pump = 1'b0;
                spc_pkg::SPC_MODE_AUTO: next_pump = auto_pump;
                spc_pkg::SPC_MODE_ON:   next_pump = 1'b1;
            endcase
            next_valve = (mode == spc_pkg::SPC_MODE_AUTO) && auto_valve;
            next_down.coll_temp       = s_coll.temp;
            next_down.coll_fault      = s_coll.open || s_coll.shorted;
            next_down.master_pump     = (mode == spc_pkg::SPC_MODE_ON) || (mode == spc_pkg::SPC_MODE_AUTO && auto_pump);
            next_down.shared_pump_cmd = (mode == spc_pkg::SPC_MODE_AUTO) && shared_cmd;
            next_up.tank_ok           = s_slave && !tank_fail;
            next_up.valve_request     = pump_valve && own_start && (mode == spc_pkg::SPC_MODE_AUTO);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pump_out      <= 1'b0;
            valve_out     <= 1'b0;
            link_down_out <= '0;
            link_up_out   <= '0;
        end else begin
            pump_out      <= next_pump;
            valve_out     <= next_valve;
            link_down_out <= next_down;
            link_up_out   <= next_up;
        end
    end

    // Lamps; the slave shows link data on its collector display
    logic [3:0] next_coll_lamp, next_tank_lamp;
    logic       next_silicon;

    always_comb begin
        next_silicon   = s_prog[spc_pkg::SEL_SILICON];
        next_tank_lamp = lamp_show(s_tank, blink);
        if (s_slave)
            next_coll_lamp = s_down.coll_fault ? {blink, 3'h0} : lamp_bar(s_down.coll_temp);
        else
            next_coll_lamp = lamp_show(s_coll, blink);
        if (ot_state == spc_pkg::SPC_OT_BLOCK && !coll_fail)
            next_coll_lamp[3:2] = {blink, blink};
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            coll_lamp      <= 4'h0;
            tank_lamp      <= 4'h0;
            sensor_silicon <= 1'b0;
        end else begin
            coll_lamp      <= next_coll_lamp;
            tank_lamp      <= next_tank_lamp;
            sensor_silicon <= next_silicon;
        end
    end

    // Checks beside the logic they guard
    a_manual_on_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick && mode == spc_pkg::SPC_MODE_ON |=> pump_out) else $error("forced on did not run pump");
    a_manual_off_stop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick && mode == spc_pkg::SPC_MODE_OFF |=> !pump_out && !valve_out) else $error("forced off left output on");
    a_over_temp_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick && coll_t > spc_pkg::OVER_ON_C |=> ot_state == spc_pkg::SPC_OT_BLOCK) else $error("lock not set");
    a_over_temp_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ot_state == spc_pkg::SPC_OT_BLOCK && !(tick && coll_t < spc_pkg::OVER_OFF_C)
        |=> ot_state == spc_pkg::SPC_OT_BLOCK) else $error("lock released early");
    a_solar_max_stop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        solar && ot_state == spc_pkg::SPC_OT_BLOCK |-> !own_start) else $error("solar start while locked");
    a_solar_tank_max: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick && solar && t11 >= max11 |=> !own_start) else $error("solar start above tank maximum");
    a_feed_min_stop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick && !solar && c11 <= max_lo ##1 !tick [*1] |-> !own_start) else $error("feed start below threshold");
    a_two_pump_yield: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick && s_slave && mode == spc_pkg::SPC_MODE_AUTO && s_down.master_pump |=> !pump_out)
        else $error("slave pump ran with master pump");
    a_coll_fail_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick && !s_slave && coll_fail && mode == spc_pkg::SPC_MODE_AUTO |=> !pump_out)
        else $error("pump on with failed collector");
    a_over_lamp_flash: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ot_state == spc_pkg::SPC_OT_BLOCK && !coll_fail |=> coll_lamp[3:2] == {2{$past(blink)}})
        else $error("lock lamps not flashing");
endmodule

//--- verif/spc_sensor_model.sv
// Behavioural sensor front end: one probe with optional open or shorted lead
`timescale 1ns/10ps
module spc_sensor_model (
    input  wire spc_pkg::spc_temp_t temp,
    input  wire logic [1:0]         fault,
    output spc_pkg::spc_sensor_t    reading
);
    // A broken lead gives no usable value, so the temperature is scrambled, not held
    always_comb begin
        reading.open    = (fault == 2'h1);
        reading.shorted = (fault == 2'h2);
        reading.temp    = (fault == 2'h0) ? temp : ~temp;
    end
endmodule

//--- verif/tb_top.sv
// Self-checking bench: master and slave controllers joined by their data link
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s expected %0h seen %0h", n, e, g); end end
module tb_top;
    localparam int SMP    = 8;
    localparam int SETTLE = 12 * SMP;
    logic               sys_clk;
    logic               rst_b;
    logic [1:0]         prog;
    logic [1:0]         mode;
    logic [3:0]         diff;
    logic [6:0]         maxs;
    spc_pkg::spc_temp_t mc_t, mt_t, sc_t, st_t;
    logic [1:0]         mc_f, mt_f, sc_f, st_f;
    spc_pkg::spc_sensor_t mc_s, mt_s, sc_s, st_s;
    spc_pkg::spc_down_t m_down, s_down;
    spc_pkg::spc_up_t   s_up;
    logic               m_sil, m_pump, m_valve, s_pump, s_valve;
    logic [3:0]         m_clamp, m_tlamp, s_clamp;
    int                 fails;
    int                 comparisons;

    spc_sensor_model u_mc (.temp(mc_t), .fault(mc_f), .reading(mc_s));
    spc_sensor_model u_mt (.temp(mt_t), .fault(mt_f), .reading(mt_s));
    spc_sensor_model u_sc (.temp(sc_t), .fault(sc_f), .reading(sc_s));
    spc_sensor_model u_st (.temp(st_t), .fault(st_f), .reading(st_s));

    // Master unit; short timers keep each settle window to a dozen ticks
    spc_controller #(.SAMPLE_CYC(SMP), .BLINK_CYC(4)) DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .program_sel(prog), .mode_sel(mode),
        .slave_role(1'h0), .diff_setting(diff), .max_setting(maxs),
        .collector_sensor(mc_s), .tank_sensor(mt_s), .link_down_in(s_down),
        .link_up_in(s_up), .link_down_out(m_down), .link_up_out(),
        .sensor_silicon(m_sil), .pump_out(m_pump), .valve_out(m_valve),
        .coll_lamp(m_clamp), .tank_lamp(m_tlamp));

    // Slave unit shares the switches; its collector input only selects the mode
    spc_controller #(.SAMPLE_CYC(SMP), .BLINK_CYC(4)) DUT_SLAVE (
        .sys_clk(sys_clk), .rst_b(rst_b), .program_sel(prog), .mode_sel(mode),
        .slave_role(1'h1), .diff_setting(diff), .max_setting(maxs),
        .collector_sensor(sc_s), .tank_sensor(st_s), .link_down_in(m_down),
        .link_up_in(2'h0), .link_down_out(s_down), .link_up_out(s_up),
        .sensor_silicon(), .pump_out(s_pump), .valve_out(s_valve),
        .coll_lamp(s_clamp), .tank_lamp());

    // Clock
    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic setup(input logic [1:0] p, m, input logic [3:0] d, input logic [6:0] x);
        @(posedge sys_clk);
        #2;
        prog = p;
        mode = m;
        diff = d;
        maxs = x;
    endtask

    // Temperatures and faults change together; several ticks pass before looking
    task automatic run(input int c, t, s, input logic [1:0] fc, ft, fs, fst);
        @(posedge sys_clk);
        #2;
        mc_t = spc_pkg::spc_temp_t'(c);
        mt_t = spc_pkg::spc_temp_t'(t);
        st_t = spc_pkg::spc_temp_t'(s);
        mc_f = fc;
        mt_f = ft;
        sc_f = fs;
        st_f = fst;
        repeat (SETTLE) @(posedge sys_clk);
        #2;
    endtask

    // Blinking lamps show as set in the union and clear in the intersection
    task automatic watch(input string n, input bit tnk, input logic [3:0] eo, ea);
        logic [3:0] o;
        logic [3:0] a;
        o = 4'h0;
        a = 4'hF;
        repeat (24) begin
            @(negedge sys_clk);
            o = o | (tnk ? m_tlamp : m_clamp);
            a = a & (tnk ? m_tlamp : m_clamp);
        end
        `CHK(n, eo, o)
        `CHK(n, ea, a)
    endtask

    initial begin
        repeat (8000) @(posedge sys_clk);
        fails++;
        give_verdict();
    end

    initial begin
        fails = 0;
        comparisons = 0;
        rst_b = 1'h0;
        {prog, mode, diff, maxs} = {2'h2, 2'h1, 4'h5, 7'h50};
        {mc_t, mt_t, sc_t, st_t} = 36'h0;
        {mc_f, mt_f, sc_f, st_f} = 8'h04;
        // Synchronous reset also clears the synchroniser stages
        repeat (2) @(posedge sys_clk);
        #2;
        rst_b = 1'h1;
        // Solar law, two-pump priority and the forwarded collector value
        run(60, 40, 30, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("master pump", 1'h1, m_pump)
        `CHK("link collector", 9'h03C, m_down.coll_temp)
        `CHK("slave pump", 1'h0, s_pump)
        `CHK("slave lamps", 4'h7, s_clamp)
        run(90, 85, 30, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("master pump", 1'h0, m_pump)
        `CHK("slave pump", 1'h1, s_pump)
        // Difference hysteresis walk
        run(60, 50, 30, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("diff on", 1'h1, m_pump)
        run(53, 50, 30, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("diff hold on", 1'h1, m_pump)
        run(52, 50, 30, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("diff off", 1'h0, m_pump)
        run(54, 50, 30, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("diff hold off", 1'h0, m_pump)
        // Collector over-temperature lock
        run(130, 40, 90, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("at limit", 1'h1, m_pump)
        run(131, 40, 90, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("locked", 1'h0, m_pump)
        watch("lock lamps", 1'h0, 4'hF, 4'h3);
        run(115, 40, 90, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("still locked", 1'h0, m_pump)
        run(109, 40, 90, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("released", 1'h1, m_pump)
        // Mode switch positions
        setup(2'h2, 2'h0, 4'h5, 7'h50);
        run(60, 40, 90, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("forced off", 1'h0, m_pump)
        setup(2'h2, 2'h3, 4'h5, 7'h50);
        run(60, 40, 90, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("code three", 1'h0, m_pump)
        setup(2'h2, 2'h2, 4'h5, 7'h50);
        run(20, 50, 90, 2'h0, 2'h1, 2'h1, 2'h0);
        `CHK("forced on", 1'h1, m_pump)
        run(140, 90, 90, 2'h1, 2'h0, 2'h1, 2'h0);
        `CHK("forced on fault", 1'h1, m_pump)
        // Sensor fault lamps in automatic
        setup(2'h2, 2'h1, 4'h5, 7'h50);
        run(60, 40, 90, 2'h0, 2'h2, 2'h1, 2'h0);
        watch("tank short", 1'h1, 4'h1, 4'h0);
        run(60, 40, 90, 2'h0, 2'h1, 2'h1, 2'h0);
        watch("tank open", 1'h1, 4'h8, 4'h0);
        run(60, 40, 30, 2'h2, 2'h0, 2'h1, 2'h0);
        watch("coll short", 1'h0, 4'h1, 4'h0);
        // Master collector loss shuts both units down
        run(60, 40, 30, 2'h1, 2'h0, 2'h1, 2'h0);
        `CHK("master off", 1'h0, m_pump)
        `CHK("slave off", 1'h0, s_pump)
        // Every selector position reaches the sensor curve output
        for (int i = 0; i < 4; i++) begin
            setup(2'(i), 2'h1, 4'h5, 7'h32);
            run(60, 40, 90, 2'h0, 2'h0, 2'h1, 2'h0);
            `CHK("sensor curve", i[0], m_sil)
        end
        // Feed program: boiler minimum and difference
        setup(2'h0, 2'h1, 4'h5, 7'h32);
        run(55, 40, 90, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("feed run", 1'h1, m_pump)
        run(45, 30, 90, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("feed below min", 1'h0, m_pump)
        run(55, 53, 90, 2'h0, 2'h0, 2'h1, 2'h0);
        `CHK("feed no diff", 1'h0, m_pump)
        // Pump-valve mode with a jumpered slave collector input
        setup(2'h2, 2'h1, 4'h5, 7'h50);
        run(60, 58, 30, 2'h0, 2'h0, 2'h2, 2'h0);
        `CHK("shared pump", 1'h1, m_pump)
        `CHK("valve", 1'h1, s_valve)
        `CHK("master valve", 1'h0, m_valve)
        run(60, 58, 30, 2'h0, 2'h0, 2'h2, 2'h2);
        `CHK("stand alone", 1'h0, m_pump)
        `CHK("valve closed", 1'h0, s_valve)
        run(60, 40, 30, 2'h0, 2'h0, 2'h2, 2'h0);
        `CHK("master own", 1'h1, m_pump)
        `CHK("valve own", 1'h0, s_valve)
        give_verdict();
    end
endmodule
